// ### rtl/i2c_four_channel_mux_ctrl.sv
`timescale 1ns/1ps
module i2c_four_channel_mux_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [2:0]  addr_select_pins,
   input  wire logic [3:0]  channel_irq_in,
   output logic [3:0]       downstream_channel_pairs,
   output logic             combined_irq_out,
   output logic             combined_irq_oe
);
   typedef enum logic [7:0] {
      ST_IDLE    = 8'h01,
      ST_ADDR    = 8'h02,
      ST_ADDR_AK = 8'h04,
      ST_WR_DATA = 8'h08,
      ST_WR_AK   = 8'h10,
      ST_RD_DATA = 8'h20,
      ST_RD_AK   = 8'h40,
      ST_IGNORE  = 8'h80
   } i2c_state_type;

   // ***************************************************
   // Pin synchronisers and bus conditions
   // ***************************************************
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   logic [2:0] asel1_ff;
   logic [2:0] asel2_ff;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
         asel1_ff    <= 3'h0;
         asel2_ff    <= 3'h0;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
         asel1_ff    <= addr_select_pins;
         asel2_ff    <= asel1_ff;
      end
   end

   assign scl_rise  = scl_sync_ff[1] && !scl_sync_ff[2];
   assign scl_fall  = !scl_sync_ff[1] && scl_sync_ff[2];
   assign start_det = scl_sync_ff[1] && scl_sync_ff[2] && !sda_sync_ff[1] && sda_sync_ff[2];
   assign stop_det  = scl_sync_ff[1] && scl_sync_ff[2] && sda_sync_ff[1] && !sda_sync_ff[2];

   // ***************************************************
   // Channel interrupt filters
   // ***************************************************
   logic [3:0] irq_active;

   for (genvar i = 0; i < mux_ctrl_pkg::NUM_CHAN; i++) begin : g_filt
      chan_irq_filter #(
         .LOW_CYC  (mux_ctrl_pkg::LOW_REJECT_CYC),
         .HIGH_CYC (mux_ctrl_pkg::HIGH_REJECT_CYC)
      ) u_filt (
         .hclk       (hclk),
         .hresetn    (hresetn),
         .irq_pin_n  (channel_irq_in[i]),
         .irq_active (irq_active[i])
      );
   end

   logic comb_irq_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comb_irq_ff <= 1'b0;
      end else begin
         comb_irq_ff <= |irq_active;
      end
   end

   assign combined_irq_out = 1'b0;
   assign combined_irq_oe  = comb_irq_ff;

   // ***************************************************
   // Serial slave state machine
   // ***************************************************
   i2c_state_type state_ff;
   logic [2:0]    bit_cnt_ff;
   logic          byte_done_ff;
   logic [7:0]    rx_ff;
   logic [7:0]    tx_ff;
   logic          rw_ff;
   logic          nack_ff;
   logic          drive_ff;
   logic [3:0]    ctrl_reg_ff;
   logic          wr_seen_ff;
   logic [3:0]    chan_en_ff;
   logic          addr_match;
   logic          applied_pulse;
   logic          addrd_pulse;
   logic [7:0]    rd_byte;

   assign addr_match = rx_ff[7:1] == {mux_ctrl_pkg::ADDR_FIXED, asel2_ff};
   assign rd_byte    = {irq_active, ctrl_reg_ff};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff     <= ST_IDLE;
         bit_cnt_ff   <= 3'h0;
         byte_done_ff <= 1'b0;
         rx_ff        <= 8'h00;
         rw_ff        <= 1'b0;
      end else if (start_det) begin
         state_ff     <= ST_ADDR;
         bit_cnt_ff   <= 3'h0;
         byte_done_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
      end else if (scl_rise) begin
         if (state_ff == ST_ADDR || state_ff == ST_WR_DATA || state_ff == ST_RD_DATA) begin
            rx_ff        <= {rx_ff[6:0], sda_sync_ff[1]};
            bit_cnt_ff   <= bit_cnt_ff + 3'h1;
            byte_done_ff <= bit_cnt_ff == 3'h7;
         end
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR: begin
               if (byte_done_ff) begin
                  byte_done_ff <= 1'b0;
                  rw_ff        <= rx_ff[0];
                  state_ff     <= addr_match ? ST_ADDR_AK : ST_IGNORE;
               end
            end
            ST_ADDR_AK: begin
               state_ff <= rw_ff ? ST_RD_DATA : ST_WR_DATA;
            end
            ST_WR_DATA: begin
               if (byte_done_ff) begin
                  byte_done_ff <= 1'b0;
                  state_ff     <= ST_WR_AK;
               end
            end
            ST_WR_AK: begin
               state_ff <= ST_WR_DATA;
            end
            ST_RD_DATA: begin
               if (byte_done_ff) begin
                  byte_done_ff <= 1'b0;
                  state_ff     <= ST_RD_AK;
               end
            end
            ST_RD_AK: begin
               state_ff <= nack_ff ? ST_IGNORE : ST_RD_DATA;
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   // Read shifter and acknowledge sampling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_ff   <= 8'hFF;
         nack_ff <= 1'b1;
      end else if (scl_rise && state_ff == ST_RD_AK) begin
         nack_ff <= sda_sync_ff[1];
      end else if (scl_fall) begin
         if ((state_ff == ST_ADDR_AK && rw_ff) || (state_ff == ST_RD_AK && !nack_ff)) begin
            tx_ff <= rd_byte;
         end else if (state_ff == ST_RD_DATA && !byte_done_ff) begin
            tx_ff <= {tx_ff[6:0], 1'b1};
         end
      end
   end

   // Data line drive changes after a falling clock edge, and is released on a start or stop condition
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drive_ff <= 1'b0;
      end else if (start_det || stop_det) begin
         drive_ff <= 1'b0;
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR:    drive_ff <= byte_done_ff && addr_match;
            ST_ADDR_AK: drive_ff <= rw_ff && !rd_byte[7];
            ST_WR_DATA: drive_ff <= byte_done_ff;
            ST_RD_DATA: drive_ff <= !byte_done_ff && !tx_ff[6];
            ST_RD_AK:   drive_ff <= !nack_ff && !rd_byte[7];
            default:    drive_ff <= 1'b0;
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = drive_ff;

   // Control register: last byte of a write wins, upper nibble is not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg_ff <= mux_ctrl_pkg::CTRL_RESET;
         wr_seen_ff  <= 1'b0;
      end else if (scl_fall && state_ff == ST_WR_DATA && byte_done_ff) begin
         ctrl_reg_ff <= rx_ff[3:0];
         wr_seen_ff  <= 1'b1;
      end else if (stop_det || start_det) begin
         wr_seen_ff <= 1'b0;
      end
   end

   // Switch enables change only on a stop condition
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_en_ff <= 4'h0;
      end else if (stop_det && wr_seen_ff) begin
         chan_en_ff <= ctrl_reg_ff[mux_ctrl_pkg::CHAN_EN_BIT] ?
                       4'(4'h1 << ctrl_reg_ff[1:0]) : 4'h0;
      end
   end

   assign downstream_channel_pairs = chan_en_ff;
   assign applied_pulse = stop_det && wr_seen_ff;
   assign addrd_pulse   = scl_fall && state_ff == ST_ADDR && byte_done_ff && addr_match;

   // ***************************************************
   // AHB-Lite slave with sticky status
   // ***************************************************
   logic        ahb_acc;
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic [31:0] hrdata_ff;
   logic [5:0]  status_ff;
   logic [5:0]  mask_ff;
   logic [3:0]  irq_prev_ff;
   logic [5:0]  stat_set;
   logic [5:0]  stat_clr;
   logic [31:0] rd_mux;

   assign ahb_acc  = hsel && hready && htrans[1];
   assign stat_set = {addrd_pulse, applied_pulse, irq_active & ~irq_prev_ff};
   assign stat_clr = (ahb_acc && !hwrite && haddr[7:0] == mux_ctrl_pkg::OFS_STATUS) ?
                     6'h3F : 6'h00;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         mux_ctrl_pkg::OFS_CTRL:   rd_mux = {24'h00_0000, rd_byte};
         mux_ctrl_pkg::OFS_STATUS: rd_mux = {26'h000_0000, status_ff};
         mux_ctrl_pkg::OFS_MASK:   rd_mux = {26'h000_0000, mask_ff};
         default:                  rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= ahb_acc && hwrite;
         if (ahb_acc) begin
            wr_addr_ff <= haddr[7:0];
         end
         if (ahb_acc && !hwrite) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff     <= mux_ctrl_pkg::MASK_RESET;
         status_ff   <= 6'h00;
         irq_prev_ff <= 4'h0;
      end else begin
         irq_prev_ff <= irq_active;
         status_ff   <= (status_ff & ~stat_clr) | stat_set;
         if (wr_pend_ff && wr_addr_ff == mux_ctrl_pkg::OFS_MASK) begin
            mask_ff <= hwdata[5:0];
         end
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(status_ff & mask_ff);

   // ***************************************************
   // Assertions
   // ***************************************************
   a_one_channel: assert property (@(posedge hclk) disable iff (!hresetn)
      $onehot0(chan_en_ff))
      else $error("more than one channel enabled");
   a_comb_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      |irq_active |=> combined_irq_oe)
      else $error("combined interrupt not asserted");
   a_comb_release: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(|irq_active) |-> ##1 !combined_irq_oe)
      else $error("combined interrupt release late");
   a_ack_match: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_ff == ST_ADDR_AK) |-> $past(rx_ff[7:1]) ==
         {mux_ctrl_pkg::ADDR_FIXED, $past(asel2_ff)} && sda_oe)
      else $error("acknowledged wrong address");
   a_ignore_foreign: assert property (@(posedge hclk) disable iff (!hresetn)
      state_ff == ST_IGNORE |-> !sda_oe)
      else $error("data line driven for foreign traffic");
   a_byte_ack: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_ff == ST_WR_AK) |-> sda_oe && wr_seen_ff)
      else $error("written byte not acknowledged");
   a_sel_on_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(chan_en_ff) |-> $past(stop_det))
      else $error("selection changed without stop");
   a_sel_decode: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(stop_det && wr_seen_ff) |-> chan_en_ff == ($past(ctrl_reg_ff[2]) ?
         4'(4'h1 << $past(ctrl_reg_ff[1:0])) : 4'h0))
      else $error("channel decode wrong");
   a_last_byte: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_ff == ST_WR_AK) |-> ctrl_reg_ff == $past(rx_ff[3:0]))
      else $error("control register not last byte");
   a_irq_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_ff == ST_RD_DATA) |-> tx_ff[7:4] == $past(irq_active))
      else $error("read nibble not interrupt state");

   c_write_sel: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(chan_en_ff != 4'h0));
   c_read_byte: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_ff == ST_RD_AK));
   c_chan_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(combined_irq_oe));
endmodule : i2c_four_channel_mux_ctrl

// ### rtl/mux_ctrl_pkg.sv
package mux_ctrl_pkg;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_PERIOD_NS    = 100;
   localparam int LOW_REJECT_NS    = 1000;
   localparam int HIGH_REJECT_NS   = 500;
   localparam int IRQ_VALID_NS     = 4000;
   localparam int IRQ_RELEASE_NS   = 2000;
   localparam int LOW_REJECT_CYC   = (LOW_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_REJECT_CYC  = (HIGH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IRQ_VALID_CYC    = IRQ_VALID_NS / CLK_PERIOD_NS;
   localparam int IRQ_RELEASE_CYC  = IRQ_RELEASE_NS / CLK_PERIOD_NS;
   // ***************************************************
   // Serial bus
   // ***************************************************
   localparam logic [3:0] ADDR_FIXED   = 4'hE;
   localparam logic [3:0] CTRL_RESET   = 4'h0;
   localparam int         CHAN_EN_BIT  = 2;
   localparam int         NUM_CHAN     = 4;
   // ***************************************************
   // AHB register map
   // ***************************************************
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_MASK     = 8'h08;
   localparam int         STAT_W       = 6;
   localparam int         STAT_CHAN    = 0;
   localparam int         STAT_APPLIED = 4;
   localparam int         STAT_ADDRD   = 5;
   localparam logic [5:0] MASK_RESET   = 6'h00;
endpackage : mux_ctrl_pkg

// ### rtl/chan_irq_filter.sv
`timescale 1ns/1ps
module chan_irq_filter #(
   parameter int LOW_CYC  = 10,
   parameter int HIGH_CYC = 5
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic irq_pin_n,
   output logic      irq_active
);
   logic       sync1_ff;
   logic       sync2_ff;
   logic       active_ff;
   logic [7:0] run_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= irq_pin_n;
         sync2_ff <= sync1_ff;
      end
   end

   // Level must differ from the filtered state for a whole window before it flips
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_ff <= 1'b0;
         run_ff    <= 8'h00;
      end else if (sync2_ff == active_ff) begin
         if (!active_ff && run_ff == 8'(LOW_CYC - 1)) begin
            active_ff <= 1'b1;
            run_ff    <= 8'h00;
         end else if (active_ff && run_ff == 8'(HIGH_CYC - 1)) begin
            active_ff <= 1'b0;
            run_ff    <= 8'h00;
         end else begin
            run_ff <= run_ff + 8'h01;
         end
      end else begin
         run_ff <= 8'h00;
      end
   end

   assign irq_active = active_ff;

   // ***************************************************
   // Assertions
   // ***************************************************
   a_low_reject: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(active_ff) |-> $past(run_ff) == 8'(LOW_CYC - 1) && !$past(sync2_ff))
      else $error("filter asserted before low window elapsed");
   a_high_reject: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(active_ff) |-> $past(run_ff) == 8'(HIGH_CYC - 1) && $past(sync2_ff))
      else $error("filter released before high window elapsed");
endmodule : chan_irq_filter

// ### tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic hclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // ******
   // Idle bus: both lines released high
   // ******
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge hclk);
   endtask : hold
   // Data moves one cycle after the clock falls; line sampled late in high phase
   task automatic bit_cycle(input logic b, output logic got);
      hold(1);
      sda_drv <= b;
      hold(3);
      scl <= 1'b1;
      hold(4);
      got = sda_line;
      scl <= 1'b0;
   endtask : bit_cycle
   task automatic start();
      hold(1);
      sda_drv <= 1'b1;
      hold(3);
      scl <= 1'b1;
      hold(4);
      sda_drv <= 1'b0;
      hold(4);
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      hold(1);
      sda_drv <= 1'b0;
      hold(3);
      scl <= 1'b1;
      hold(4);
      sda_drv <= 1'b1;
      hold(8);
   endtask : stop
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], a);
      end
      bit_cycle(1'b1, a);
      ack = ~a;
   endtask : wr_byte
   // Single byte, closed by a not-acknowledge
   task automatic rd_byte(output logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(1'b1, a);
   endtask : rd_byte
endmodule : i2c_master_model

// ### tb/i2c_four_channel_mux_ctrl_tb.sv
`timescale 1ns/1ps
module i2c_four_channel_mux_ctrl_tb;
   // ******
   // Signals
   // ******
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        sda_out, sda_oe, scl, sda_drv, sda_line, ack, seen;
   logic        combined_irq_out, combined_irq_oe;
   logic [31:0] haddr, hwdata, hrdata, rd, rnd_state;
   logic [1:0]  htrans;
   logic [2:0]  hsize, pins;
   logic [3:0]  chan_irq_n, sel, cur_sel, ctrl;
   logic [7:0]  rb, d;
   int          bad_count, check_count;
   assign sda_line = sda_oe ? 1'b0 : sda_drv;
   always #50 hclk = ~hclk;
   i2c_four_channel_mux_ctrl i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pins(pins), .channel_irq_in(chan_irq_n),
      .downstream_channel_pairs(sel), .combined_irq_out(combined_irq_out),
      .combined_irq_oe(combined_irq_oe));
   i2c_master_model i_master (
      .hclk(hclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
   // ******
   // Helpers
   // ******
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [3:0] exp_sel(input logic [3:0] c);
      return c[mux_ctrl_pkg::CHAN_EN_BIT] ? 4'h1 << c[1:0] : 4'h0;
   endfunction : exp_sel
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) begin
         bad_count++;
         end_of_test();
      end
   endtask : wait_rdy
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   // Bound is the allowed latency of the combined output
   task automatic wait_oe(input logic v, input int lim);
      int k;
      k = 0;
      while (combined_irq_oe !== v && k < lim) begin
         @(posedge hclk);
         k++;
      end
      check(32'(combined_irq_oe), 32'(v));
      if (combined_irq_oe !== v) end_of_test();
   endtask : wait_oe
   task automatic ser_rd(output logic [7:0] v);
      i_master.start();
      i_master.wr_byte({mux_ctrl_pkg::ADDR_FIXED, pins, 1'b1}, ack);
      i_master.rd_byte(v);
      i_master.stop();
   endtask : ser_rd
   // ******
   // Main sequence
   // ******
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      pins = 3'h0;
      chan_irq_n = 4'hF;
      bad_count = 0;
      check_count = 0;
      cur_sel = 4'h0;
      ctrl = 4'h0;
      rnd_state = 32'h0C41F394;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      check(sel, 32'h0);
      ahb(1'b0, mux_ctrl_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      check(32'(hresp), 32'h0);
      check(32'(sda_out), 32'h0);
      check(32'(combined_irq_out), 32'h0);
      ahb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 10; i++) begin
         rnd_state = xs(rnd_state);
         pins <= rnd_state[2:0];
         d = (i == 0) ? 8'hF7 : (i == 9) ? 8'h05 : rnd_state[15:8];
         i_master.start();
         i_master.wr_byte({mux_ctrl_pkg::ADDR_FIXED, rnd_state[2:0], 1'b0}, ack);
         check(32'(ack), 32'h1);
         repeat (rnd_state[17:16] % 3) i_master.wr_byte(~d, ack);
         i_master.wr_byte(d, ack);
         check(32'(ack), 32'h1);
         check(sel, cur_sel);
         i_master.stop();
         cur_sel = exp_sel(d[3:0]);
         ctrl = d[3:0];
         check(sel, cur_sel);
         check(32'($onehot0(sel)), 32'h1);
         ahb(1'b0, mux_ctrl_pkg::OFS_STATUS, 32'h0);
         check(rd, 32'h30);
         ser_rd(rb);
         check(rb, {4'h0, ctrl});
      end
      // Foreign address is neither acknowledged nor obeyed
      i_master.start();
      i_master.wr_byte({mux_ctrl_pkg::ADDR_FIXED, ~pins, 1'b0}, ack);
      check(32'(ack), 32'h0);
      i_master.wr_byte(8'h06, ack);
      i_master.stop();
      check(sel, cur_sel);
      // Interrupt filtering and combining
      ahb(1'b1, mux_ctrl_pkg::OFS_MASK, 32'h04);
      ahb(1'b0, mux_ctrl_pkg::OFS_MASK, 32'h0);
      check(rd, 32'h04);
      ahb(1'b0, mux_ctrl_pkg::OFS_STATUS, 32'h0);
      chan_irq_n[1] <= 1'b0;
      repeat (8) @(posedge hclk);
      chan_irq_n[1] <= 1'b1;
      seen = 1'b0;
      repeat (30) begin
         @(posedge hclk);
         seen = seen | combined_irq_oe;
      end
      check(32'(seen), 32'h0);
      chan_irq_n[2] <= 1'b0;
      wait_oe(1'b1, 40);
      check(32'(irq), 32'h1);
      repeat (5) @(posedge hclk);
      chan_irq_n[2] <= 1'b1;
      repeat (4) @(posedge hclk);
      chan_irq_n[2] <= 1'b0;
      seen = 1'b1;
      repeat (20) begin
         @(posedge hclk);
         seen = seen & combined_irq_oe;
      end
      check(32'(seen), 32'h1);
      ser_rd(rb);
      check(rb, {4'h4, ctrl});
      ahb(1'b0, mux_ctrl_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'hF, 32'h4);
      check(32'(irq), 32'h0);
      chan_irq_n[2] <= 1'b1;
      wait_oe(1'b0, 20);
      // Reset in mid-run drops the selected channel
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      check(sel, 32'h0);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(1'b0, mux_ctrl_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      end_of_test();
   end
endmodule : i2c_four_channel_mux_ctrl_tb
